// >>> src/pic_edge_det.sv
// Rising edge detector for a group of level conditions.
// Assumes the levels are synchronous to clk_i.
`timescale 1ns/1ps
module pic_edge_det #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels and edge pulses
  input  wire logic [W-1:0] lvl_i,
  output      logic [W-1:0] rise_o
);

  logic [W-1:0] prev_r;

  // Previous level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= lvl_i;
    end
  end

  // One cycle pulse per rising edge
  assign rise_o = lvl_i & ~prev_r;

endmodule

// >>> src/pic_pkg.sv
// Constants and carrier types of the prioritized interrupt controller.
// Assumes a single 250 MHz clock and a classic Wishbone register port.
package pic_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Source table
  localparam int          N_SRC      = 26;             // Slots 0..25, slot 0 is reset
  localparam int          SRC_W      = 5;
  localparam logic [25:0] VALID_MASK = 26'h277_E0FE;   // Slots that can post
  localparam logic [25:0] GPIO_MASK  = 26'h070_0060;   // Edge posted port slots
  localparam int          GPIO_N     = 5;
  localparam int          GPIO_SLOT0 = 5;
  localparam int          GPIO_SLOT1 = 6;
  localparam int          GPIO_SLOT2 = 20;
  localparam int          GPIO_SLOT3 = 21;
  localparam int          GPIO_SLOT4 = 22;
  localparam int          VEC_SHIFT  = 2;              // Vector is priority times four

  ////////////////////////////////////////////////////////////////////////
  // Dispatch timing, in CPU clock cycles
  localparam int          DISP_CYCLES = 13;
  localparam int          LONG_JUMP_INSTR_CYCLES = 7;             // Table jump, run by the CPU
  localparam logic [3:0]  CYC_PUSH_HI = 4'h0;
  localparam logic [3:0]  CYC_PUSH_LO = 4'h1;
  localparam logic [3:0]  CYC_PUSH_FL = 4'h2;
  localparam logic [3:0]  CYC_FL_CLR  = 4'h3;
  localparam int          FLAG_IE_BIT = 0;             // Global enable in CPU flags

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets
  localparam logic [7:0]  OFS_POSTED  = 8'h00;
  localparam logic [7:0]  OFS_MASK    = 8'h04;
  localparam logic [7:0]  OFS_CTRL    = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0C;
  localparam int          CTRL_SOFT_BIT = 0;
  localparam logic [25:0] RST_POSTED  = 26'h000_0000;
  localparam logic [25:0] RST_MASK    = 26'h000_0000;
  localparam logic        RST_SOFT    = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Carriers toward the CPU
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pic_push_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } pic_pcld_t;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b01,
    PIC_DISP = 2'b10
  } pic_state_t;

endpackage

// >>> src/pic_prio_enc.sv
// Priority encoder: lowest set index wins.
// Assumes pending bits are already masked.
`timescale 1ns/1ps
module pic_prio_enc #(
  parameter int N = 26,
  parameter int W = 5
) (
  // Pending requests
  input  wire logic [N-1:0] pend_i,
  // Winner
  output      logic         any_o,
  output      logic [W-1:0] idx_o
);

  // Scan from low priority upward so the highest priority is last written
  always_comb begin
    any_o = |pend_i;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        idx_o = W'(i);
      end
    end
  end

endmodule

// >>> src/pic_top.sv
// Prioritized interrupt controller with CPU dispatch sequencer.
// Assumes a classic Wishbone master and a CPU that flags instruction ends.
//
// Overview of operation
// RULE1: Fixed priority, vector is priority times four
// RULE2: Condition latches posted flag until taken/cleared
// RULE3: Posted and masked-in flags are pending
// RULE4: Mask never clears nor blocks posting
// RULE5: Highest pending taken only with global enable
// RULE6: Event, mask update or enable rise activates
// RULE7: Current instruction completes before dispatch
// RULE8: Dispatch lasts thirteen clock cycles
// RULE9: Push PC high, PC low, then flags
// RULE10: Clear all CPU flags after pushing
// RULE11: PC high zeroed, vector into PC low
// RULE12: Return restores PC and flags, enable
// RULE13: Pending work dispatched before next instruction
// RULE14: Re-enabling inside handler allows nesting
// RULE15: Latency is remainder plus thirteen plus seven
// RULE16: Read shows posted, writing zero clears
// RULE17: Writing one posts only with soft enable
// RULE18: Port interrupts post on edges
// RULE19: Event beats a coinciding software clear
// RULE20: Taking clears only the dispatched source
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module pic_top #(
  parameter int DISP_CYCLES = pic_pkg::DISP_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output      logic [31:0]            wb_dat_o,
  output      logic                   wb_ack_o,
  // Interrupt sources
  input  wire logic [25:0]            src_evt_i,
  input  wire logic [4:0]             gpio_lvl_i,
  // CPU side
  input  wire logic                   instr_done_i,
  input  wire logic [15:0]            cpu_program_counter_i,
  input  wire logic [7:0]             cpu_flags_i,
  output      logic                   irq_req_o,
  output      logic                   disp_busy_o,
  output      pic_pkg::pic_push_t     push_o,
  output      logic                   flags_clear_o,
  output      pic_pkg::pic_pcld_t     pc_load_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  pic_pkg::pic_state_t state_r, state_nxt;
  logic [3:0]          cnt_r, cnt_nxt;
  logic [25:0]         posted_r, posted_nxt;
  logic [25:0]         mask_r;
  logic                soft_en_r;
  logic [25:0]         pend, hw_evt, lane, clr_wr, set_sw, take_mask, evt_q_r;
  logic [4:0]          gpio_rise;
  logic                any_pend, global_irq_enable, req_now, start, wr_stb, rd_stb;
  logic [4:0]          sel_idx, take_src_r;
  logic [7:0]          vec_r;
  logic [15:0]         pc_cap_r, pc_src;
  logic [7:0]          fl_cap_r, fl_src;
  logic [31:0]         rd_data;

  // Elaboration check: pushes, clear and load must fit a 4 bit count
  if (DISP_CYCLES < 5 || DISP_CYCLES > 16) begin : g_bad_disp
    $error("DISP_CYCLES must lie in 5..16");
  end

  ////////////////////////////////////////////////////////////////////////
  // Sources: port edges and the priority encoder
  pic_edge_det #(.W(pic_pkg::GPIO_N)) u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .lvl_i  (gpio_lvl_i),
    .rise_o (gpio_rise)
  );

  // Port slots take edges only, other slots take event pulses
  always_comb begin
    hw_evt = src_evt_i & ~pic_pkg::GPIO_MASK;                      // see RULE18
    hw_evt[pic_pkg::GPIO_SLOT0] = gpio_rise[0];
    hw_evt[pic_pkg::GPIO_SLOT1] = gpio_rise[1];
    hw_evt[pic_pkg::GPIO_SLOT2] = gpio_rise[2];
    hw_evt[pic_pkg::GPIO_SLOT3] = gpio_rise[3];
    hw_evt[pic_pkg::GPIO_SLOT4] = gpio_rise[4];
  end

  // Pending is posted and unmasked
  assign pend = posted_r & mask_r;                                 // see RULE3

  pic_prio_enc #(.N(pic_pkg::N_SRC), .W(pic_pkg::SRC_W)) u_enc (
    .pend_i (pend),
    .any_o  (any_pend),
    .idx_o  (sel_idx)
  );

  // Request, dispatch start at an instruction boundary
  assign global_irq_enable     = cpu_flags_i[pic_pkg::FLAG_IE_BIT];              // see RULE12
  assign req_now = any_pend & global_irq_enable;                                 // see RULE5
  assign start   = (state_r == pic_pkg::PIC_IDLE) & instr_done_i & req_now; // see RULE7

  ////////////////////////////////////////////////////////////////////////
  // Posted flags
  assign wr_stb    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_stb    = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign lane      = 26'({{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
  assign clr_wr    = (wr_stb && wb_adr_i == pic_pkg::OFS_POSTED) ? (lane & ~wb_dat_i[25:0]) : '0;
  assign set_sw    = (wr_stb && wb_adr_i == pic_pkg::OFS_POSTED && soft_en_r) ?
                     (lane & wb_dat_i[25:0]) : '0;                 // see RULE17
  assign take_mask = start ? (26'h000_0001 << sel_idx) : '0;      // see RULE20

  // Clears first, sets last so an event is never lost
  assign posted_nxt = ((posted_r & ~clr_wr & ~take_mask) | set_sw | hw_evt)
                      & pic_pkg::VALID_MASK;                       // see RULE2 RULE16 RULE19

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      posted_r <= pic_pkg::RST_POSTED;
    end else begin
      posted_r <= posted_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask and control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_r    <= pic_pkg::RST_MASK;
      soft_en_r <= pic_pkg::RST_SOFT;
    end else if (wr_stb) begin
      if (wb_adr_i == pic_pkg::OFS_MASK) begin
        mask_r <= ((mask_r & ~lane) | (wb_dat_i[25:0] & lane)) & pic_pkg::VALID_MASK; // see RULE4
      end
      if (wb_adr_i == pic_pkg::OFS_CTRL && wb_sel_i[0]) begin
        soft_en_r <= wb_dat_i[pic_pkg::CTRL_SOFT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone read mux and acknowledge
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      pic_pkg::OFS_POSTED: rd_data = {6'h00, posted_r};
      pic_pkg::OFS_MASK:   rd_data = {6'h00, mask_r};
      pic_pkg::OFS_CTRL:   rd_data = {31'h0000_0000, soft_en_r};
      pic_pkg::OFS_STATUS: rd_data = {16'h0000, disp_busy_o, any_pend, 6'h00, vec_r};
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  // Single wait state answer, unmapped reads give zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_stb) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dispatch sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      pic_pkg::PIC_IDLE: begin
        if (start) begin
          state_nxt = pic_pkg::PIC_DISP;
          cnt_nxt   = 4'h0;
        end
      end
      pic_pkg::PIC_DISP: begin
        if (cnt_r == 4'(DISP_CYCLES - 1)) begin                   // see RULE8
          state_nxt = pic_pkg::PIC_IDLE;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      default: begin
        state_nxt = pic_pkg::PIC_IDLE;
        cnt_nxt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= pic_pkg::PIC_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Capture PC, flags and vector at the start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_cap_r   <= 16'h0000;
      fl_cap_r   <= 8'h00;
      vec_r      <= 8'h00;
      take_src_r <= 5'h00;
    end else if (start) begin
      pc_cap_r   <= cpu_program_counter_i;
      fl_cap_r   <= cpu_flags_i;
      vec_r      <= {1'b0, sel_idx, 2'b00};                        // see RULE1
      take_src_r <= sel_idx;
    end
  end

  assign pc_src = start ? cpu_program_counter_i : pc_cap_r;
  assign fl_src = start ? cpu_flags_i : fl_cap_r;

  // Registered CPU outputs aligned to the dispatch count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_o     <= 1'b0;
      disp_busy_o   <= 1'b0;
      push_o        <= '0;
      flags_clear_o <= 1'b0;
      pc_load_o     <= '0;
    end else begin
      irq_req_o     <= req_now;                                    // see RULE6 RULE13 RULE14
      disp_busy_o   <= state_nxt == pic_pkg::PIC_DISP;
      push_o.valid  <= state_nxt == pic_pkg::PIC_DISP && cnt_nxt <= pic_pkg::CYC_PUSH_FL; // see RULE9
      unique case (cnt_nxt)
        pic_pkg::CYC_PUSH_HI: push_o.data <= pc_src[15:8];
        pic_pkg::CYC_PUSH_LO: push_o.data <= pc_src[7:0];
        default:              push_o.data <= fl_src;
      endcase
      flags_clear_o <= state_nxt == pic_pkg::PIC_DISP && cnt_nxt == pic_pkg::CYC_FL_CLR; // see RULE10
      pc_load_o.valid <= state_nxt == pic_pkg::PIC_DISP && cnt_nxt == 4'(DISP_CYCLES - 1);
      pc_load_o.value <= {8'h00, (start ? {1'b0, sel_idx, 2'b00} : vec_r)}; // see RULE11 RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_q_r <= '0;
    end else begin
      evt_q_r <= hw_evt & pic_pkg::VALID_MASK;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_disp_len:   assert property ($rose(disp_busy_o) |-> disp_busy_o[*8] ##1 disp_busy_o[*5] ##1 !disp_busy_o) // see RULE8
    else $error("dispatch length wrong");
  a_push_three: assert property ($rose(disp_busy_o) |-> push_o.valid[*3] ##1 !push_o.valid) // see RULE9
    else $error("push count wrong");
  a_push_hi:    assert property ($rose(disp_busy_o) |-> push_o.data == pc_cap_r[15:8] // see RULE9
                  ##1 push_o.data == pc_cap_r[7:0] ##1 push_o.data == fl_cap_r)
    else $error("push order wrong");
  a_flag_clr:   assert property ($rose(disp_busy_o) |-> ##3 flags_clear_o) // see RULE10
    else $error("flags not cleared");
  a_pc_vector:  assert property ($rose(disp_busy_o) |-> ##12 pc_load_o.valid // see RULE11
                  && pc_load_o.value == (16'(take_src_r) << pic_pkg::VEC_SHIFT))
    else $error("vector load wrong");
  a_start_cond: assert property ($rose(disp_busy_o) |-> $past(instr_done_i) && $past(global_irq_enable) // see RULE5
                  && $past(any_pend))
    else $error("dispatch without enabled request");
  a_take_one:   assert property ($rose(disp_busy_o) |-> !posted_r[take_src_r] || evt_q_r[take_src_r]) // see RULE20
    else $error("taken flag not cleared");
  a_set_wins:   assert property (1'b1 |=> (posted_r & evt_q_r) == evt_q_r) // see RULE19
    else $error("event lost");
  a_mask_keep:  assert property (wr_stb && wb_adr_i == pic_pkg::OFS_MASK && !start // see RULE4
                  |=> (posted_r & $past(posted_r)) == $past(posted_r))
    else $error("mask write cleared a flag");
  a_wb_ack:     assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer wrong");

  // Gating, reserved slots and quiet outputs
  a_irq_gated:  assert property (!global_irq_enable |=> !irq_req_o) // see RULE5
    else $error("request without global enable");
  a_no_reserved: assert property ((posted_r & ~pic_pkg::VALID_MASK) == 26'h000_0000) // see RULE1
    else $error("reserved slot posted");
  a_soft_off:   assert property (wr_stb && wb_adr_i == pic_pkg::OFS_POSTED && !soft_en_r // see RULE17
                  |=> (posted_r & ~$past(posted_r) & ~evt_q_r) == 26'h000_0000)
    else $error("written one posted without soft enable");
  a_idle_quiet: assert property (!disp_busy_o |-> !push_o.valid && !flags_clear_o && !pc_load_o.valid) // see RULE8
    else $error("dispatch output outside dispatch");
  a_pc_high:    assert property (pc_load_o.valid |-> pc_load_o.value[15:8] == 8'h00) // see RULE11
    else $error("vector high byte not zero");

  c_dispatch:   cover property ($rose(disp_busy_o));
  c_soft_post:  cover property (|set_sw);
  c_back2back:  cover property ($fell(disp_busy_o) ##[1:4] $rose(disp_busy_o));
  c_set_clear:  cover property (|(hw_evt & clr_wr));

endmodule

// >>> tb/pic_cpu_model.sv
// Behavioural CPU facing the dispatch sequencer: stalls, stacks, returns.
// Assumes the bench clock and active high reset; set_ie_i sets the flags.
`timescale 1ns/1ps
module pic_cpu_model (
  // Clock, reset, bench control
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               set_ie_i,
  // Controller side
  input  wire logic               busy_i,
  input  wire pic_pkg::pic_push_t push_i,
  input  wire logic               flags_clear_i,
  input  wire pic_pkg::pic_pcld_t pc_load_i,
  output      logic               instr_done_o,
  output      logic [15:0]        pc_o,
  output      logic [7:0]         flags_o
);
  logic [2:0] cnt_r;
  logic [2:0] len_r;
  logic [1:0] isr_r;
  logic [1:0] sp_r;
  logic [7:0] stk_r [3];

  // Instructions end only outside dispatch
  assign instr_done_o = !busy_i && (cnt_r == len_r);

  ////////////////////////////////////////////////////////////
  // Execution, stack, flags and return
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r   <= '0;
      len_r   <= 3'h2;
      isr_r   <= '0;
      sp_r    <= '0;
      pc_o    <= 16'h1234;
      flags_o <= 8'h00;
    end else begin
      if (busy_i) begin
        cnt_r <= '0;
      end else if (instr_done_o) begin
        cnt_r <= '0;
        len_r <= 3'($urandom_range(4, 1)); // 2 to 5 cycle instructions
        if (isr_r == 2'd1) begin
          pc_o    <= {stk_r[0], stk_r[1]};
          flags_o <= stk_r[2];
          len_r   <= 3'd0; // Boundary right after return
        end
        if (isr_r != 2'd0) isr_r <= isr_r - 2'd1;
      end else begin
        cnt_r <= cnt_r + 3'd1;
        if (cnt_r == 3'd0) pc_o <= pc_o + 16'h0001;
      end
      if (push_i.valid) begin
        stk_r[sp_r] <= push_i.data;
        sp_r        <= sp_r + 2'd1;
      end
      if (flags_clear_i) flags_o <= 8'h00;
      if (pc_load_i.valid) begin
        pc_o  <= pc_load_i.value;
        isr_r <= 2'd3;
        sp_r  <= '0;
      end
      if (set_ie_i) flags_o <= 8'h5b;
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the interrupt controller with a CPU model.
// Assumes a 250 MHz clock and the one wait state Wishbone slave.
`timescale 1ns/1ps
module testbench;
  localparam logic [25:0] VM = pic_pkg::VALID_MASK;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq_req, busy, fclr, done, set_ie;
  logic [7:0]  wb_adr, flags;
  logic [3:0]  wb_sel, bc;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [25:0] src_evt, evt_q, p;
  logic [4:0]  gpio, r;
  logic [15:0] pc;
  pic_pkg::pic_push_t push;
  pic_pkg::pic_pcld_t pcld;
  int          failures, cmp_count, n, lb;
  logic [7:0]  vecs[$];

  pic_top i_pic_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .src_evt_i(src_evt), .gpio_lvl_i(gpio), .instr_done_i(done), .cpu_program_counter_i(pc), .cpu_flags_i(flags),
    .irq_req_o(irq_req), .disp_busy_o(busy), .push_o(push), .flags_clear_o(fclr), .pc_load_o(pcld));
  pic_cpu_model i_pic_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .set_ie_i(set_ie), .busy_i(busy),
    .push_i(push), .flags_clear_i(fclr), .pc_load_i(pcld), .instr_done_o(done), .pc_o(pc), .flags_o(flags));

  ////////////////////////////////////////////////////////////
  // Checks, bus cycle, verdict
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t bus got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_disp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t dispatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    src_evt <= evt_q;
    @(posedge clk_i);
    src_evt <= '0;
    evt_q = '0;
    k = 0;
    while (wb_ack !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (wb_ack !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    chk_bus(rd, exp);
  endtask
  function automatic logic [25:0] gmap(input logic [4:0] v);
    gmap = '0;
    gmap[pic_pkg::GPIO_SLOT0] = v[0];
    gmap[pic_pkg::GPIO_SLOT1] = v[1];
    gmap[pic_pkg::GPIO_SLOT2] = v[2];
    gmap[pic_pkg::GPIO_SLOT3] = v[3];
    gmap[pic_pkg::GPIO_SLOT4] = v[4];
  endfunction

  ////////////////////////////////////////////////////////////
  // Dispatch monitor: length, pushed bytes, flag clear, vector
  always @(posedge clk_i) begin
    if (busy === 1'b1) begin
      if (bc < 4'd3) chk_disp({23'h0, push.valid, push.data}, {23'h0, 1'b1, bc == 0 ? pc[15:8] : bc == 1 ? pc[7:0] : flags});
      if (bc == 4'd3) chk_disp({31'h0, fclr}, 32'h0000_0001);
      if (pcld.valid === 1'b1) begin
        chk_disp({12'h0, bc, pcld.value[15:8]}, {12'h0, 4'(pic_pkg::DISP_CYCLES - 1), 8'h00});
        vecs.push_back(pcld.value[7:0]);
      end
      bc <= bc + 4'd1;
    end else begin
      if (bc != 4'd0) chk_disp({28'h0, bc}, pic_pkg::DISP_CYCLES);
      bc <= '0;
    end
  end

  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, set_ie} = 5'b10000;
    {wb_adr, wb_wdat, src_evt, evt_q, gpio, bc} = '0;
    wb_sel = 4'hf;
    failures = 0;
    cmp_count = 0;
    void'($urandom(32'h1d6797d7));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 5; a++) rd_chk(8'(a * 4), 32'h0000_0000);
    wb(1'b1, 8'h10, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0000_0000);
    wb(1'b1, pic_pkg::OFS_POSTED, 32'h03ff_ffff);
    rd_chk(pic_pkg::OFS_POSTED, 32'h0000_0000);
    wb(1'b1, pic_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (6) begin
      p = 26'($urandom) & VM;
      wb(1'b1, pic_pkg::OFS_POSTED, {6'h0, p});
      rd_chk(pic_pkg::OFS_POSTED, {6'h0, p});
    end
    // Event against a software clear in the same cycle
    evt_q = (26'($urandom) & VM & ~pic_pkg::GPIO_MASK) | 26'h000_0002;
    p = evt_q;
    wb(1'b1, pic_pkg::OFS_POSTED, 32'h0000_0000);
    rd_chk(pic_pkg::OFS_POSTED, {6'h0, p});
    wb(1'b1, pic_pkg::OFS_POSTED, 32'h0000_0000);
    // Port conditions post on rising edges only
    gpio <= 5'h1f;
    repeat (4) @(posedge clk_i);
    rd_chk(pic_pkg::OFS_POSTED, {6'h0, pic_pkg::GPIO_MASK});
    wb(1'b1, pic_pkg::OFS_POSTED, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    rd_chk(pic_pkg::OFS_POSTED, 32'h0000_0000);
    gpio <= '0;
    r = 5'($urandom) | 5'h01;
    repeat (3) @(posedge clk_i);
    gpio <= r;
    repeat (4) @(posedge clk_i);
    rd_chk(pic_pkg::OFS_POSTED, {6'h0, gmap(r)});
    // Byte lanes: only selected bytes of the mask change
    wb_sel <= 4'h5;
    wb(1'b1, pic_pkg::OFS_MASK, 32'hffff_ffff);
    wb_sel <= 4'hf;
    rd_chk(pic_pkg::OFS_MASK, {6'h0, VM} & 32'h00ff_00ff);
    // Dispatch rounds: held off, then released by enable or mask
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, pic_pkg::OFS_MASK, 32'h0000_0000);
      p = (26'($urandom) & VM) | 26'h000_0002;
      wb(1'b1, pic_pkg::OFS_POSTED, {6'h0, p});
      if (i == 0) wb(1'b1, pic_pkg::OFS_MASK, {6'h0, VM});
      repeat (12) @(posedge clk_i);
      chk_disp({30'h0, busy, irq_req}, 32'h0000_0000);
      if (i == 0) begin
        set_ie <= 1'b1;
        @(posedge clk_i);
        set_ie <= 1'b0;
      end else begin
        wb(1'b1, pic_pkg::OFS_MASK, {6'h0, VM});
      end
      n = 0;
      while (vecs.size() < $countones(p) && n < 3000) begin
        @(posedge clk_i);
        n++;
      end
      chk_disp(32'(vecs.size()), 32'($countones(p)));
      if (n == 3000) report_and_stop();
      for (int b = 1; b < 26; b++) if (p[b]) begin
        chk_disp(32'(vecs.pop_front()), 32'(b * 4));
        lb = b;
      end
      repeat (40) @(posedge clk_i);
      rd_chk(pic_pkg::OFS_POSTED, 32'h0000_0000);
      rd_chk(pic_pkg::OFS_STATUS, 32'(lb * 4));
    end
    report_and_stop();
  end
endmodule
